/* File: dac_update_control_defs.vh */
`ifndef DAC_UPDATE_CONTROL_DEFS_VH
`define DAC_UPDATE_CONTROL_DEFS_VH
// Register byte addresses on the bus
`define DAC_CONTROL_ADDR      12'h000
`define DAC_CODE_LOW_ADDR     12'h004
`define DAC_CODE_HIGH_ADDR    12'h008
`define DAC_STATUS_ADDR       12'h00c
// Control field positions
`define CTL_ENABLE_BIT        0
`define CTL_PIN_DRIVE_BIT     1
`define CTL_LEFT_ALIGN_BIT    2
`define CTL_TRIG_SEL_LSB      4
`define CTL_TRIG_SEL_MSB      6
`define CTL_AUTO_TRIG_BIT     7
// Reset values
`define CTL_RESET             8'h00
`define CODE_RESET            8'h00
// Conversion busy time in ns and in cycles at 250 MHz
`define CONV_TIME_NS          1000
`define CLK_PERIOD_NS         4
`define CONV_CYCLES           ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: dac_update_control.v */
// Behaviour
// R1: Control bit 0 enables the converter
// R2: Control bit 1 routes result to pin
// R3: Alignment change applies at next high write; in auto mode the code applies it at the next trigger load instead
// R4: Left align: high=9..2, low top=1..0
// R5: Right align: low=7..0, high low=9..8
// R6: Bit 7 picks trigger edge or high write
// R7: Bits 6..4 select one of eight triggers
// R8: Trigger is rising flag edge, enables ignored
// R9: Held-high trigger restarts no conversion
// R10: Edges during conversion are dropped
// R11: Software clears the flag after each event
// R12: Hidden shadow loads only on update event
// R13: Low write alone never changes output
// R14: Software writes low then high byte
// R15: Auto mode needs high written before loading
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dac_update_control_defs.vh"

// Update flow in brief:
// - Software writes the control byte and the code byte pair.
// - The byte pair is staging only; the converter sees the shadow.
// - Normal mode: a high-byte write copies the pair into the shadow.
// - Auto mode: a fresh rising edge of the chosen flag copies it.
// - An auto copy opens a busy window; edges inside it are lost.
// - A flag left high gives no second copy until it is cleared.
// - Alignment is sampled at the copy, so a change waits for one.
// Timing, counted in clock edges:
// - Edge 0 takes the address phase, edge 1 ends the data phase.
// - A write lands at edge 1; a normal-mode shadow load with it.
// - convertedCode and the route outputs follow one edge later.
// - A fresh flag edge seen at edge k loads the shadow at edge k.
// - converting rises at edge k+1 and stays for CONV_CYCLES samples.
// Status word at its own offset:
// - bit 0 busy window open
// - bit 1 high byte written since reset
// - bit 2 shadow loaded at least once
// - bit 3 alignment used by the last shadow load
// Limitations:
// - Register offsets and the status word are local choices.
// - The busy window is a parameter, not a measured settling time.
// - hsize is not checked; narrow writes act on the low byte lane.
// - Read data is captured in the address phase, so a read right
//   after a write to the same register returns the older value.
// Reset:
// - Synchronous and active low; every register takes its reset value in one edge.
// - hreadyout comes out of reset high, hresp low.
// - The shadow and the code output start at zero.
// Hazards:
// - Changing the trigger select to a flag that is already high
//   looks like a fresh edge and may load the shadow at once.
// - A high write that falls inside a busy window is kept, and
//   the next fresh edge after the window loads it.
// - Disabling the converter zeroes the output but keeps the shadow,
//   so enabling again restores the last loaded code.

module dac_update_control #(
    parameter CODE_WIDTH  = 10,
    parameter CONV_CYCLES = `CONV_CYCLES
) (
    // Clock and reset
    input  wire                  clk,
    input  wire                  rst_n,
    // Register bus
    input  wire                  hsel,
    input  wire [31:0]           haddr,
    input  wire [1:0]            htrans,
    input  wire                  hwrite,
    input  wire [2:0]            hsize,
    input  wire [31:0]           hwdata,
    input  wire                  hready,
    output reg  [31:0]           hrdata,
    output reg                   hreadyout,
    output reg                   hresp,
    // Selected peripheral flags
    input  wire [7:0]            triggerFlags,
    // Converter side
    output reg  [CODE_WIDTH-1:0] convertedCode,
    output reg                   converterEnable,
    output reg                   analogPinDrive,
    output reg                   internalOnly,
    output reg                   converting
);

    // One-hot conversion states
    localparam [1:0]  CONV_IDLE = 2'b01;
    localparam [1:0]  CONV_RUN  = 2'b10;
    // Sized copy of the busy length so the counter load is an exact cut
    localparam [31:0] CONV_LOAD_FULL = CONV_CYCLES;
    localparam [15:0] CONV_LOAD      = CONV_LOAD_FULL[15:0];

    // Software-visible bytes
    reg  [7:0]            converterControlReg;
    reg  [7:0]            codeHighByte;
    reg  [7:0]            codeLowByte;

    // Hidden state behind the byte pair
    reg                   leftAlignLatched;
    reg  [CODE_WIDTH-1:0] shadowCode;
    reg                   highPending;
    reg                   trigPrev;
    reg                   loadSeen;

    // Conversion window; counter width allows windows far beyond the default
    reg  [1:0]            convState;
    reg  [15:0]           convCount;

    // Data phase bookkeeping
    reg                   dataWrite;
    reg  [11:0]           dataAddr;

    // Control fields
    wire       convEnableBit = converterControlReg[`CTL_ENABLE_BIT];
    wire       pinDriveBit   = converterControlReg[`CTL_PIN_DRIVE_BIT];
    wire       autoTriggerOn = converterControlReg[`CTL_AUTO_TRIG_BIT];
    wire       leftAlign     = converterControlReg[`CTL_LEFT_ALIGN_BIT];
    wire [2:0] triggerSelect =
        converterControlReg[`CTL_TRIG_SEL_MSB:`CTL_TRIG_SEL_LSB];

    // Assemble the code from the byte pair for one alignment
    function [9:0] pack_code;
        input       left;
        input [7:0] hi;
        input [7:0] lo;
        begin
            if (left) begin
                pack_code = {hi, lo[7:6]};
            end else begin
                pack_code = {hi[1:0], lo};
            end
        end
    endfunction

    // Match a captured word offset against one register offset
    function is_reg;
        input [11:0] addr;
        input [11:0] offset;
        begin
            is_reg = (addr == offset);
        end
    endfunction

    // High byte as software sees it; right alignment hides six bits
    function [7:0] high_view;
        input       left;
        input [7:0] hi;
        begin
            if (left) begin
                high_view = hi;
            end else begin
                high_view = {6'h00, hi[1:0]};                   // [R5]
            end
        end
    endfunction

    // Low byte as software sees it; left alignment hides six bits
    function [7:0] low_view;
        input       left;
        input [7:0] lo;
        begin
            if (left) begin
                low_view = {lo[7:6], 6'h00};                    // [R4]
            end else begin
                low_view = lo;
            end
        end
    endfunction

    // Address phase capture; the data phase follows with no wait state
    wire addrValid = hsel & hready & htrans[1];
    wire wrHigh    = dataWrite & is_reg(dataAddr, `DAC_CODE_HIGH_ADDR);
    wire wrLow     = dataWrite & is_reg(dataAddr, `DAC_CODE_LOW_ADDR);
    wire wrCtl     = dataWrite & is_reg(dataAddr, `DAC_CONTROL_ADDR);

    // Selected flag; only its edge counts, never its interrupt enable
    wire trigLevel = triggerFlags[triggerSelect];               // [R7]
    wire trigRise  = trigLevel & ~trigPrev;                     // [R8] [R9]
    wire busy      = (convState == CONV_RUN);

    // Update event: high write in normal mode, edge when idle in auto
    wire autoLoad  = autoTriggerOn & trigRise & ~busy & highPending; // [R10] [R15]
    wire normLoad  = ~autoTriggerOn & wrHigh;                   // [R6]
    wire loadEvent = autoLoad | normLoad;                       // [R13]
    // The new high byte is on hwdata in the cycle of its own write
    wire [7:0] loadHigh = wrHigh ? hwdata[7:0] : codeHighByte;

    // Data phase sequencing; the bus never waits and never errors
    // Only writes need the captured address; reads are muxed at once
    always @(posedge clk) begin
        if (!rst_n) begin
            dataWrite <= 1'b0;
            dataAddr  <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dataWrite <= addrValid & hwrite;
            dataAddr  <= haddr[11:0];
        end
    end

    // Control byte; bit 3 has no function and reads as zero
    always @(posedge clk) begin
        if (!rst_n) begin
            converterControlReg <= `CTL_RESET;
        end else if (wrCtl) begin
            converterControlReg <= {hwdata[7:4], 1'b0, hwdata[2:0]};
        end
    end

    // Code byte pair; these only stage the value, the shadow is what counts
    always @(posedge clk) begin
        if (!rst_n) begin
            codeHighByte <= `CODE_RESET;
            codeLowByte  <= `CODE_RESET;
        end else begin
            if (wrHigh) begin
                codeHighByte <= hwdata[7:0];
            end
            if (wrLow) begin
                codeLowByte <= hwdata[7:0];                     // [R13]
            end
        end
    end

    // Read mux, registered so hrdata comes from a flop
    always @(posedge clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addrValid & ~hwrite) begin
            case (haddr[11:0])
                `DAC_CONTROL_ADDR: begin
                    hrdata <= {24'h000000, converterControlReg};
                end
                `DAC_CODE_HIGH_ADDR: begin
                    hrdata <= {24'h000000, high_view(leftAlign, codeHighByte)};
                end
                `DAC_CODE_LOW_ADDR: begin
                    hrdata <= {24'h000000, low_view(leftAlign, codeLowByte)};
                end
                `DAC_STATUS_ADDR: begin
                    hrdata <= {28'h0000000, leftAlignLatched, loadSeen, highPending, busy};
                end
                default: begin
                    hrdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Trigger history; one flop is enough because flags are synchronous
    // Resets low to match the idle level of the flags
    always @(posedge clk) begin
        if (!rst_n) begin
            trigPrev <= 1'b0;
        end else begin
            trigPrev <= trigLevel;                              // [R9]
        end
    end

    // A high write arms auto updates and stays armed, so 8-bit use
    // loads on every trigger without touching the low byte again
    always @(posedge clk) begin
        if (!rst_n) begin
            highPending <= 1'b0;
        end else if (wrHigh) begin
            highPending <= 1'b1;                                // [R15]
        end
    end

    // Shadow code and alignment latch; the shadow is hidden, the latch reads as status bit 3
    always @(posedge clk) begin
        if (!rst_n) begin
            shadowCode       <= {CODE_WIDTH{1'b0}};
            leftAlignLatched <= 1'b0;
            loadSeen         <= 1'b0;
        end else if (loadEvent) begin
            shadowCode       <= pack_code(leftAlign, loadHigh, codeLowByte); // [R12] [R4] [R5]
            leftAlignLatched <= leftAlign;                      // [R3]
            loadSeen         <= 1'b1;
        end
    end

    // Conversion window: opens on an auto copy and counts down to idle
    // Edges during the window are not queued; the counter simply runs out
    always @(posedge clk) begin
        if (!rst_n) begin
            convState <= CONV_IDLE;
            convCount <= 16'h0000;
        end else begin
            case (convState)
                CONV_IDLE: begin
                    if (autoLoad) begin
                        convState <= CONV_RUN;
                        convCount <= CONV_LOAD;                 // [R10]
                    end
                end
                CONV_RUN: begin
                    if (convCount <= 16'h0001) begin
                        convState <= CONV_IDLE;
                        convCount <= 16'h0000;
                    end else begin
                        convCount <= convCount - 16'h0001;
                    end
                end
                default: begin
                    convState <= CONV_IDLE;
                    convCount <= 16'h0000;
                end
            endcase
        end
    end

    // Route outputs: the pin and the internal path never both claim it
    always @(posedge clk) begin
        if (!rst_n) begin
            converterEnable <= 1'b0;
            analogPinDrive  <= 1'b0;
            internalOnly    <= 1'b0;
        end else begin
            converterEnable <= convEnableBit;                   // [R1]
            analogPinDrive  <= convEnableBit & pinDriveBit;     // [R2]
            internalOnly    <= convEnableBit & ~pinDriveBit;    // [R2]
        end
    end

    // Code and busy outputs
    always @(posedge clk) begin
        if (!rst_n) begin
            convertedCode <= {CODE_WIDTH{1'b0}};
            converting    <= 1'b0;
        end else begin
            // Disabled converter presents zero rather than a stale code
            convertedCode <= convEnableBit ? shadowCode : {CODE_WIDTH{1'b0}}; // [R1]
            converting    <= busy;
        end
    end

endmodule // dac_update_control

`default_nettype wire

/* File: trigger_source.sv */
`timescale 1ns/1ps
`default_nettype none
module trigger_source (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       evt,
    input  wire logic [2:0] evtSel,
    input  wire logic       clr,
    output var  logic [7:0] flags
);
    // Flags stick until software clears them, so a held flag gives no new edge
    always_ff @(posedge clk) begin
        if (!rst_n || clr)
            flags <= 8'h00;
        else if (evt)
            flags <= flags | (8'h01 << evtSel);
    end
endmodule // trigger_source
`default_nettype wire

/* File: dac_update_control_props.sv */
`timescale 1ns/1ps
`default_nettype none
module dac_update_control_props #(parameter CONV_CYCLES = 8) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] triggerFlags,
    input wire logic [9:0] convertedCode,
    input wire logic       converterEnable,
    input wire logic       analogPinDrive,
    input wire logic       internalOnly,
    input wire logic       converting
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] busyCnt;
    // Counter avoids a long repetition for the busy length
    always_ff @(posedge clk)
        busyCnt <= (converting && rst_n) ? busyCnt + 16'h0001 : 16'h0000;
    route_excl_a: assert property (!(analogPinDrive && internalOnly))
        else $error("pin and internal both set");
    pin_needs_en_a: assert property (analogPinDrive |-> converterEnable)
        else $error("pin driven while disabled");
    en_route_a: assert property (converterEnable == (analogPinDrive || internalOnly))
        else $error("enable without a route");
    off_zero_a: assert property (!converterEnable |-> convertedCode == 10'h000)
        else $error("code out while disabled");
    busy_len_a: assert property (converting |-> busyCnt < CONV_CYCLES)
        else $error("conversion too long");
    busy_full_a: assert property ($fell(converting) |-> busyCnt == CONV_CYCLES)
        else $error("conversion length wrong");
    trig_cause_a: assert property ($rose(converting) |-> $past(triggerFlags) != 8'h00)
        else $error("conversion without trigger");
    code_hold_a: assert property (converting && $past(converting) |-> $stable(convertedCode))
        else $error("code changed while busy");
    cover property ($rose(converting));
    cover property ($rose(analogPinDrive));
    cover property ($fell(converting));
endmodule // dac_update_control_props
bind dac_update_control dac_update_control_props #(.CONV_CYCLES(CONV_CYCLES)) props (
    .clk, .rst_n, .triggerFlags, .convertedCode, .converterEnable, .analogPinDrive,
    .internalOnly, .converting);
`default_nettype wire

/* File: dac_update_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dac_update_control_tb;
    logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, evt = 0, clr = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 0, evtSel = 0;
    logic [7:0]  flags;
    logic [9:0]  code;
    logic        hreadyout, hresp, en, pin, intl, busy;
    int          num_errors = 0, n_tests = 0, cyc = 0;
    typedef struct packed {logic [7:0] c, l, h; logic [9:0] p, code; logic pin;} row_t;
    row_t        rows [4] = '{'{8'h03, 8'h5a, 8'h03, 10'h000, 10'h35a, 1'b1},
        '{8'h07, 8'hc0, 8'hff, 10'h35a, 10'h3ff, 1'b1}, '{8'h05, 8'h40, 8'h80, 10'h3ff,
        10'h201, 1'b0}, '{8'h04, 8'hff, 8'hff, 10'h000, 10'h000, 1'b0}};
    always #2 clk = ~clk;
    dac_update_control #(.CONV_CYCLES(8)) uut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .triggerFlags(flags),
        .convertedCode(code), .converterEnable(en), .analogPinDrive(pin), .internalOnly(intl),
        .converting(busy));
    trigger_source far (.clk, .rst_n, .evt, .evtSel, .clr, .flags);
    task finish_test;
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Single transfer; each phase holds until hready is seen high
    task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        hsel <= 1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Clearing first guarantees a fresh rising edge
    task fire(input logic [2:0] s);
        evtSel <= s;
        clr <= 1;
        @(posedge clk);
        clr <= 0;
        evt <= 1;
        @(posedge clk);
        evt <= 0;
        for (int i = 0; i < 10 && busy !== 1'b1; i++) @(posedge clk);
    endtask
    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            finish_test;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        xfer(0, 12'h008, 0);
        chk(rd, 0);
        xfer(0, 12'h010, 0);
        chk(rd, 0);
        foreach (rows[i]) begin
            xfer(1, 12'h000, rows[i].c);
            repeat (3) @(posedge clk);
            chk(32'(code), 32'(rows[i].p));
            xfer(1, 12'h004, rows[i].l);
            xfer(1, 12'h008, rows[i].h);
            repeat (3) @(posedge clk);
            chk(32'(code), 32'(rows[i].code));
            chk(32'(pin), 32'(rows[i].pin));
            chk(32'(en), 32'(rows[i].c[0]));
            chk(32'(intl), 32'(rows[i].c[0] & ~rows[i].c[1]));
            chk(32'(hresp), 0);
            xfer(1, 12'h004, 8'h00);
            repeat (3) @(posedge clk);
            chk(32'(code), 32'(rows[i].code));
        end
        $display("Normal mode rows done");
        for (int s = 0; s < 8; s++) begin
            xfer(1, 12'h000, {1'b1, 3'(s), 4'h1});
            xfer(1, 12'h004, 8'(s * 5));
            xfer(1, 12'h008, 8'h02);
            repeat (3) @(posedge clk);
            if (s > 0) chk(32'(code), {22'h0, 2'b10, 8'((s - 1) * 5)});
            fire(3'(s));
            chk(32'(busy), 1);
            repeat (2) @(posedge clk);
            chk(32'(code), {22'h0, 2'b10, 8'(s * 5)});
            repeat (10) @(posedge clk);
        end
        xfer(1, 12'h008, 8'h01);
        fire(3'h7);
        xfer(1, 12'h008, 8'h03);
        fire(3'h7);
        repeat (14) @(posedge clk);
        chk(32'(code), 32'h123);
        chk(32'(busy), 0);
        fire(3'h7);
        repeat (3) @(posedge clk);
        chk(32'(code), 32'h323);
        $display("Auto trigger tests done");
        xfer(1, 12'h000, 8'h01);
        xfer(1, 12'h008, 8'hff);
        xfer(0, 12'h008, 0);
        chk(rd, 32'h3);
        xfer(1, 12'h000, 8'h0f);
        xfer(0, 12'h000, 0);
        chk(rd, 32'h07);
        rst_n <= 0;
        repeat (4) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        chk(32'(code), 0);
        xfer(0, 12'h004, 0);
        chk(rd, 0);
        xfer(0, 12'h00c, 0);
        chk(rd, 0);
        $display("Readback and reset tests done");
        finish_test;
    end
endmodule // dac_update_control_tb
`default_nettype wire
